/* hdl/sps_pin_sync.sv */
`timescale 1ns/1ns
// =========================================================
// three-stage pin synchroniser; a new level is accepted only
// when stages two and three agree, filtering a metastable bit
module sps_pin_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // pin and clean level
    input  wire logic pin,
    output logic      level
);

    logic [2:0] stage;
    logic       next_level;

    // stage 0 is read only by stage 1
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= sps_pkg::RESET_SYNC;
        end else begin
            stage <= {stage[1:0], pin};
        end
    end

    assign next_level = (stage[1] == stage[2]) ? stage[2] : level;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end

endmodule

/* hdl/sps_regs.sv */
`timescale 1ns/1ns
// Contract
// - programmed marker (control bit 4) is cleared to zero on reset.
// - status bit D3 shows a copy of the programmed marker.
// - scaler soft reset bit zero holds the whole scaler path idle.
// - writing the scaler soft reset bit to one releases the scaler path.
// - first analog channel powered down when its enable is zero, else active.
// - second analog channel (control bit 7) powered down when zero, else active.
// - status D7 shows live level of expansion-port three-state pin.
// - status D6 shows live level of image-port three-state pin.
// - status D5 shows the output FIFO almost-filled flag.
// - status D4 shows the output FIFO overflow flag.
// - status D2 shows the output formatter rate-conflict error flag.
// - status D1 shows the field ID at the scaler input.
// - status D0 shows the field ID at the scaler output.
// - status reads return live values with no latching or capture.
// - scaler power-down bit one stops scaler and image-port output.
module sps_regs (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // serial control bus register access
    input  wire sps_pkg::sps_bus_req_t      bus_req,
    output logic [7:0]                      rdata,
    output logic                            rdata_valid,
    // lower control half held elsewhere; scaler power-down level
    input  wire logic                       scaler_power_down,
    // asynchronous pins
    input  wire logic                       expansion_port_tristate_pin,
    input  wire logic                       image_port_tristate_pin,
    // scaler internal state, same clock
    input  wire sps_pkg::sps_scaler_state_t scaler_state,
    // power and reset controls to the datapath
    output sps_pkg::sps_power_ctl_t         power_ctl,
    output logic [3:0]                      control_upper
);

    // =========================================================
    // control register (upper half) and decode
    logic [7:0] power_save_control;
    logic       ctl_write;
    logic       status_write;
    logic       ctl_read;
    logic       status_read;
    logic       exp_tri_level;
    logic       img_tri_level;
    logic [7:0] scaler_status;
    logic [7:0] next_rdata;

    assign ctl_write    = bus_req.wr_en && (bus_req.addr == sps_pkg::ADDR_POWER_SAVE_CONTROL);
    assign status_write = bus_req.wr_en && (bus_req.addr == sps_pkg::ADDR_SCALER_STATUS);
    assign ctl_read     = bus_req.rd_en && (bus_req.addr == sps_pkg::ADDR_POWER_SAVE_CONTROL);
    assign status_read  = bus_req.rd_en && (bus_req.addr == sps_pkg::ADDR_SCALER_STATUS);

    // only the upper half lives here; lower bits read as zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            power_save_control <= sps_pkg::RESET_POWER_SAVE_CONTROL;
        end else if (ctl_write) begin
            power_save_control <= {bus_req.wdata[7:4], sps_pkg::RESET_POWER_SAVE_CONTROL[3:0]};
        end
    end

    // status_write deliberately reaches no storage
    assign control_upper = power_save_control[7:4];

    // =========================================================
    // pin synchronisers
    sps_pin_sync u_exp_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin   (expansion_port_tristate_pin),
        .level (exp_tri_level)
    );

    sps_pin_sync u_img_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin   (image_port_tristate_pin),
        .level (img_tri_level)
    );

    // =========================================================
    // live status assembly; nothing captured ahead of the read
    assign scaler_status[sps_pkg::BIT_ST_EXP_TRI]   = exp_tri_level;
    assign scaler_status[sps_pkg::BIT_ST_IMG_TRI]   = img_tri_level;
    assign scaler_status[sps_pkg::BIT_ST_FIFO_FILL] = scaler_state.fifo_almost_filled_flag;
    assign scaler_status[sps_pkg::BIT_ST_FIFO_OVF]  = scaler_state.fifo_overflow_flag;
    assign scaler_status[sps_pkg::BIT_ST_PROG_COPY] =
        power_save_control[sps_pkg::BIT_PROGRAMMED_MARKER];
    assign scaler_status[sps_pkg::BIT_ST_OF_ERR]    = scaler_state.output_formatter_error;
    assign scaler_status[sps_pkg::BIT_ST_FID_IN]    = scaler_state.scaler_input_field_id;
    assign scaler_status[sps_pkg::BIT_ST_FID_OUT]   = scaler_state.scaler_output_field_id;

    // read mux; unmapped subaddresses return zero
    assign next_rdata = status_read ? scaler_status :
                        ctl_read    ? power_save_control : 8'h00;

    // sampled on the read cycle itself, so the value is that of the read moment
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata       <= 8'h00;
            rdata_valid <= 1'b0;
        end else begin
            rdata       <= next_rdata;
            rdata_valid <= bus_req.rd_en;
        end
    end

    // =========================================================
    // power and reset controls
    assign power_ctl.scaler_hold_idle =
        !power_save_control[sps_pkg::BIT_SCALER_SOFT_RESET];
    assign power_ctl.scaler_stopped = scaler_power_down;
    assign power_ctl.image_port_output_enable =
        !scaler_power_down && power_save_control[sps_pkg::BIT_SCALER_SOFT_RESET];
    assign power_ctl.first_analog_channel_power_up =
        power_save_control[sps_pkg::BIT_FIRST_CHAN_ENABLE];
    assign power_ctl.second_analog_channel_power_up =
        power_save_control[sps_pkg::BIT_SECOND_CHAN_ENABLE];

    // =========================================================
    // assertions
    a_marker_reset_clear: assert property (@(posedge mclk)
        $rose(rst_n) |-> !power_save_control[sps_pkg::BIT_PROGRAMMED_MARKER])
        else $error("marker not clear after reset");

    a_marker_copy_match: assert property (@(posedge mclk) disable iff (!rst_n)
        status_read |=> rdata[sps_pkg::BIT_ST_PROG_COPY] ==
            $past(power_save_control[sps_pkg::BIT_PROGRAMMED_MARKER]))
        else $error("status copy differs from marker");

    a_soft_reset_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_write && !bus_req.wdata[sps_pkg::BIT_SCALER_SOFT_RESET] |=> power_ctl.scaler_hold_idle)
        else $error("scaler not held idle");

    sequence s_release_write;
        ctl_write && bus_req.wdata[sps_pkg::BIT_SCALER_SOFT_RESET];
    endsequence
    a_soft_reset_release: assert property (@(posedge mclk) disable iff (!rst_n)
        s_release_write |=> !power_ctl.scaler_hold_idle)
        else $error("scaler not released");

    a_first_chan_ctl: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_write |=> power_ctl.first_analog_channel_power_up ==
            $past(bus_req.wdata[sps_pkg::BIT_FIRST_CHAN_ENABLE]))
        else $error("first channel power wrong");

    a_second_chan_ctl: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_write |=> power_ctl.second_analog_channel_power_up ==
            $past(bus_req.wdata[sps_pkg::BIT_SECOND_CHAN_ENABLE]))
        else $error("second channel power wrong");

    a_status_live_flags: assert property (@(posedge mclk) disable iff (!rst_n)
        status_read |=> rdata[5:4] == $past({scaler_state.fifo_almost_filled_flag,
                                             scaler_state.fifo_overflow_flag}) &&
                        rdata[2:0] == $past({scaler_state.output_formatter_error,
                                             scaler_state.scaler_input_field_id,
                                             scaler_state.scaler_output_field_id}))
        else $error("status flags not live");

    a_status_pin_level: assert property (@(posedge mclk) disable iff (!rst_n)
        status_read |=> rdata[7:6] == $past({exp_tri_level, img_tri_level}))
        else $error("status pin levels wrong");

    a_power_down_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        scaler_power_down |-> !power_ctl.image_port_output_enable)
        else $error("image port active in power-down");

    a_status_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
        status_write && !ctl_write |=> $stable(power_save_control))
        else $error("status write altered control");

endmodule

/* shared/sps_pkg.sv */
package sps_pkg;

    // =========================================================
    // register map (serial control bus subaddresses)
    localparam logic [7:0] ADDR_POWER_SAVE_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_SCALER_STATUS      = 8'h8f;

    // =========================================================
    // power_save_control field positions (upper half, plus lower-half scaler power-down bit 1)
    localparam int BIT_PROGRAMMED_MARKER = 4;
    localparam int BIT_SCALER_SOFT_RESET = 5;
    localparam int BIT_FIRST_CHAN_ENABLE = 6;
    localparam int BIT_SECOND_CHAN_ENABLE = 7;
    localparam int BIT_SCALER_POWER_DOWN = 1;

    // =========================================================
    // scaler_status field positions
    localparam int BIT_ST_EXP_TRI   = 7;
    localparam int BIT_ST_IMG_TRI   = 6;
    localparam int BIT_ST_FIFO_FILL = 5;
    localparam int BIT_ST_FIFO_OVF  = 4;
    localparam int BIT_ST_PROG_COPY = 3;
    localparam int BIT_ST_OF_ERR    = 2;
    localparam int BIT_ST_FID_IN    = 1;
    localparam int BIT_ST_FID_OUT   = 0;

    // =========================================================
    // reset values
    localparam logic [7:0] RESET_POWER_SAVE_CONTROL = 8'h00;
    localparam logic [2:0] RESET_SYNC               = 3'h0;

    // =========================================================
    // carriers
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sps_bus_req_t;

    typedef struct packed {
        logic fifo_almost_filled_flag;
        logic fifo_overflow_flag;
        logic output_formatter_error;
        logic scaler_input_field_id;
        logic scaler_output_field_id;
    } sps_scaler_state_t;

    typedef struct packed {
        logic scaler_hold_idle;
        logic scaler_stopped;
        logic image_port_output_enable;
        logic first_analog_channel_power_up;
        logic second_analog_channel_power_up;
    } sps_power_ctl_t;

endpackage

/* tb/tb.sv */
`timescale 1ns/1ns
// ======================================
// bench for the power-save control and scaler status bank
module tb;
    logic                       mclk;
    logic                       rst_n;
    logic                       spd;
    logic                       exp_pin;
    logic                       img_pin;
    sps_pkg::sps_bus_req_t      req;
    sps_pkg::sps_scaler_state_t st;
    sps_pkg::sps_power_ctl_t    pc;
    logic [7:0]                 rdata;
    logic                       rv;
    logic [3:0]                 cu;
    logic [7:0]                 d;
    int                         mismatches;
    int                         tests_run;
    int                         cycles;

    sps_regs DUT (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .rdata(rdata), .rdata_valid(rv),
        .scaler_power_down(spd), .expansion_port_tristate_pin(exp_pin),
        .image_port_tristate_pin(img_pin), .scaler_state(st), .power_ctl(pc), .control_upper(cu));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // hang guard; the full run needs about 140 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            results();
        end
    end

    // ======================================
    // shared bus and compare tasks
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        req = '{1'b1, 1'b0, a, v};
        @(negedge mclk);
        req.wr_en = 1'b0;
        repeat (2) @(negedge mclk);
    endtask

    // s lands on the scaler state in the same cycle as the strobe, so a capture ahead of the read shows up
    task automatic rd(input logic [7:0] a, input sps_pkg::sps_scaler_state_t s, output logic [7:0] q);
        int n;
        @(negedge mclk);
        req = '{1'b0, 1'b1, a, 8'h00};
        st = s;
        @(negedge mclk);
        req.rd_en = 1'b0;
        n = 0;
        while (rv !== 1'b1 && n < 3) begin
            @(negedge mclk);
            n++;
        end
        q = rdata;
        chk("rdata_valid", 8'h01, {7'h0, rv});
    endtask

    // ======================================
    // scenarios
    task automatic t_reset();
        rd(8'h88, st, d);
        chk("control after reset", 8'h00, d);
        chk("control_upper", 8'h00, {4'h0, cu});
        chk("power_ctl idle", 8'h10, {3'h0, pc});
        rd(8'h8f, st, d);
        chk("marker copy", 8'h00, d & 8'h08);
        $display("test reset done");
    endtask

    task automatic t_ctrl();
        logic [7:0] vals [6] = '{8'h10, 8'h20, 8'h40, 8'h80, 8'hff, 8'h00};
        foreach (vals[i]) begin
            wr(8'h88, vals[i]);
            rd(8'h88, st, d);
            chk("control readback", vals[i] & 8'hf0, d);
            chk("control_upper", {4'h0, vals[i][7:4]}, {4'h0, cu});
            chk("power_ctl", {3'h0, ~vals[i][5], 1'b0, vals[i][5], vals[i][6], vals[i][7]}, {3'h0, pc});
            rd(8'h8f, st, d);
            chk("marker copy", {4'h0, vals[i][4], 3'h0}, d & 8'h08);
        end
        $display("test control done");
    endtask

    task automatic t_status();
        logic [7:0] v;
        wr(8'h88, 8'h10);
        for (int i = 0; i < 9; i++) begin
            v = (i < 8) ? (8'h01 << i) : 8'hf7;
            if (i != 3) begin
                exp_pin = v[7];
                img_pin = v[6];
                repeat (5) @(negedge mclk);
                rd(8'h8f, {v[5], v[4], v[2], v[1], v[0]}, d);
                chk("status", (v & 8'hf7) | 8'h08, d);
            end
        end
        rd(8'h8f, 5'h00, d);
        chk("status live", 8'hc8, d);
        $display("test status done");
    endtask

    task automatic t_power();
        wr(8'h88, 8'h20);
        @(negedge mclk);
        spd = 1'b1;
        @(negedge mclk);
        chk("power_ctl stopped", 8'h08, {3'h0, pc});
        spd = 1'b0;
        @(negedge mclk);
        chk("power_ctl running", 8'h04, {3'h0, pc});
        $display("test power done");
    endtask

    task automatic t_ro();
        wr(8'h8f, 8'hff);
        wr(8'h55, 8'hff);
        rd(8'h88, st, d);
        chk("control kept", 8'h20, d);
        rd(8'h8f, 5'h00, d);
        chk("status kept", 8'hc0, d);
        rd(8'h55, st, d);
        chk("unmapped read", 8'h00, d);
        $display("test read-only done");
    endtask

    task automatic results();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ======================================
    // main sequence
    initial begin
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        rst_n = 1'b0;
        spd = 1'b0;
        exp_pin = 1'b0;
        img_pin = 1'b0;
        req = '0;
        st = '0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_ctrl();
        t_status();
        t_power();
        t_ro();
        results();
    end
endmodule
